/* hw/mfp_params.svh */
/*
 * Register map, field positions, reset values and counts for the
 * multifunction pin controller. Assumes a 16-bit APB address.
 */
`ifndef MFP_PARAMS_SVH
`define MFP_PARAMS_SVH

`define MFP_CTRL_ADDR    16'h4038
`define MFP_IRQ_STS_ADDR 16'h4040
`define MFP_IRQ_MSK_ADDR 16'h4044
`define MFP_PIN_STS_ADDR 16'h4048

`define MFP_DIR_BIT      15
`define MFP_PULL_HI      14
`define MFP_PULL_LO      13
`define MFP_MODE_BIT     12
`define MFP_DOM_BIT      11
`define MFP_POL_BIT      10
`define MFP_OD_BIT       9
`define MFP_ENA_BIT      7
`define MFP_FN_HI        3
`define MFP_FN_LO        0

`define MFP_CTRL_RESET   16'ha400
`define MFP_CTRL_WMASK   16'hfe8f

`define MFP_IRQ_EDGE_BIT 0

`define MFP_PIN_RAW_BIT  0
`define MFP_PIN_ACT_BIT  1
`define MFP_PIN_OE_BIT   2

`define MFP_DB_TICKS     16'h0400
`define MFP_DB_CNT_W     16

`endif

/* hw/mfp_pkg.sv */
/*
 * Types shared by the multifunction pin controller files.
 * Assumes mfp_params.svh supplies the numeric constants.
 */
package mfp_pkg;
    typedef enum logic [1:0] {
        MFP_PULL_NONE = 2'h0,
        MFP_PULL_DOWN = 2'h1,
        MFP_PULL_UP   = 2'h2,
        MFP_PULL_RSVD = 2'h3
    } mfp_pull_e;

    typedef logic [3:0] mfp_fn_t;
endpackage

/* hw/mfp_debounce.sv */
/*
 * Long debounce filter: the output follows the input only after the
 * input has held a new level for TICKS low-frequency ticks.
 * Assumes lf_tick is a one-cycle pulse on the mclk domain.
 */
`include "mfp_params.svh"
module mfp_debounce
    import mfp_pkg::*;
#(
    parameter logic [`MFP_DB_CNT_W-1:0] TICKS = `MFP_DB_TICKS
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic raw,
    input  wire logic lf_tick,
    output logic      stable
);
    typedef struct packed {
        logic [`MFP_DB_CNT_W-1:0] cnt;
        logic                     out;
    } mfp_db_s;

    mfp_db_s s_q;
    mfp_db_s s_d;

    always_comb begin
        s_d = s_q;
        if (raw == s_q.out) begin
            s_d.cnt = '0;
        end else if (lf_tick) begin
            if (s_q.cnt >= TICKS - 1'b1) begin
                s_d.out = raw;
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign stable = s_q.out;

    db_change_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(s_q.out) |-> $past(lf_tick) && $past(raw) == s_q.out
            && $past(s_q.cnt) == TICKS - 1'b1)
        else $error("debounced level changed without full count");
endmodule

/* hw/mfp_edge_detect.sv */
/*
 * Interrupt edge detector on the pin's active level.
 * Assumes level already carries the polarity inversion.
 */
module mfp_edge_detect
    import mfp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic level,
    input  wire logic both_edges,
    input  wire logic enable,
    output logic      pulse
);
    typedef struct packed {
        logic prev;
        logic pulse;
    } mfp_edge_s;

    mfp_edge_s s_q;
    mfp_edge_s s_d;

    always_comb begin
        s_d       = s_q;
        s_d.prev  = level;
        if (both_edges) begin
            s_d.pulse = enable && (level != s_q.prev);
        end else begin
            s_d.pulse = enable && level && !s_q.prev;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pulse = s_q.pulse;

    single_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !both_edges && enable && $past(enable) && $changed(level)
            |=> pulse == $past(level))
        else $error("single-edge mode missed or took the wrong edge");

    both_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
        both_edges && enable && $past(enable) && $changed(level) |=> pulse)
        else $error("dual-edge mode missed an edge");
endmodule

/* hw/mfp_pin_ctrl.sv */
/*
 * Multifunction pin controller: control register, function routing,
 * output driver control, debounce and pin interrupt behind APB.
 * Assumes all inputs are synchronous to mclk and an APB3 master.
 */
// Function
// - pull field selects none, down or up
// - mode 0 interrupts on active-going edge only
// - mode 1 interrupts on both pin edges
// - supply bit picks buffer or always-on supply
// - polarity 0 inverts pin sense, reset 1
// - open-drain bit selects driver type
// - disabled pin stays tri-stated
// - direction selects input or output function decode
// - input codes 2-6 are power requests
// - input 7 watchdog kick, 8-9 voltage selects
// - input 10-15 hardware enables and controls
// - output 0 gpio level, 1 slow clock
// - output 2-4 power state indications
// - output 10-13 enables and supply good
// - output 14 power clock, 15 aux reset
`include "mfp_params.svh"
module mfp_pin_ctrl
    import mfp_pkg::*;
#(
    parameter logic [`MFP_DB_CNT_W-1:0] DB_TICKS = `MFP_DB_TICKS
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe,
    output logic             pull_up_en,
    output logic             pull_down_en,
    output logic             supply_sel,
    input  wire logic        lf_clk,
    input  wire logic        pin_out_level,
    input  wire logic        osc_clk_slow,
    input  wire logic        on_state,
    input  wire logic        sleep_state,
    input  wire logic        state_change,
    input  wire logic        dvs_done_one,
    input  wire logic        dvs_done_two,
    input  wire logic        ext_power_enable_one,
    input  wire logic        ext_power_enable_two,
    input  wire logic        system_supply_good,
    input  wire logic        converter_power_good,
    input  wire logic        ext_power_clk,
    input  wire logic        aux_reset,
    output logic             gp_input_level,
    output logic             power_toggle_req,
    output logic             sleep_wake_req,
    output logic             sleep_req,
    output logic             power_on_req,
    output logic             watchdog_kick,
    output logic             voltage_scale_select_one,
    output logic             voltage_scale_select_two,
    output logic             hw_enable_one,
    output logic             hw_enable_two,
    output logic             hw_control_one,
    output logic             hw_control_two
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic        irq_sts;
        logic        irq_msk;
        logic        pin;
        logic        lf;
        logic        lf_tick;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        pin_out;
        logic        pin_oe;
        logic        pu;
        logic        pd;
        logic        dom;
        logic [11:0] in_fn;
    } mfp_pin_s;

    mfp_pin_s   s_q;
    mfp_pin_s   s_d;
    logic       pin_direction;
    mfp_pull_e  pin_pull_select;
    logic       pin_irq_edge_mode;
    logic       pin_supply_domain;
    logic       pin_polarity;
    logic       pin_open_drain;
    logic       pin_enable;
    mfp_fn_t    pin_function_select;
    logic       active_raw;
    logic       active_db;
    logic       active_eff;
    logic       long_db;
    logic       in_mode;
    logic       out_mode;
    logic       edge_pulse;
    logic       access;
    logic       out_src;
    logic       out_lvl;
    logic [15:0] in_hit;

    assign pin_direction       = s_q.ctrl[`MFP_DIR_BIT];
    assign pin_pull_select     =
        mfp_pull_e'(s_q.ctrl[`MFP_PULL_HI:`MFP_PULL_LO]);
    assign pin_irq_edge_mode   = s_q.ctrl[`MFP_MODE_BIT];
    assign pin_supply_domain   = s_q.ctrl[`MFP_DOM_BIT];
    assign pin_polarity        = s_q.ctrl[`MFP_POL_BIT];
    assign pin_open_drain      = s_q.ctrl[`MFP_OD_BIT];
    assign pin_enable          = s_q.ctrl[`MFP_ENA_BIT];
    assign pin_function_select = s_q.ctrl[`MFP_FN_HI:`MFP_FN_LO];

    assign in_mode  = pin_enable && pin_direction;
    assign out_mode = pin_enable && !pin_direction;
    // active level of the pin after polarity; polarity 0 means active low
    assign active_raw = s_q.pin ^ !pin_polarity;
    assign long_db = (pin_function_select == 4'h0)
                  || (pin_function_select == 4'h4)
                  || (pin_function_select == 4'he)
                  || (pin_function_select == 4'hf);
    assign active_eff = long_db ? active_db : active_raw;

    mfp_debounce #(
        .TICKS   (DB_TICKS)
    ) u_debounce (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .raw     (active_raw),
        .lf_tick (s_q.lf_tick),
        .stable  (active_db)
    );

    mfp_edge_detect u_edge (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .level      (active_eff),
        .both_edges (pin_irq_edge_mode),
        .enable     (in_mode),
        .pulse      (edge_pulse)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_hit
            assign in_hit[gi] = in_mode && active_eff
                             && (pin_function_select == mfp_fn_t'(gi));
        end
    endgenerate

    // output source mux; reserved codes 5 to 7 drive the inactive level
    always_comb begin
        case (pin_function_select)
            4'h0:    out_src = pin_out_level;
            4'h1:    out_src = osc_clk_slow;
            4'h2:    out_src = on_state;
            4'h3:    out_src = sleep_state;
            4'h4:    out_src = state_change;
            4'h8:    out_src = dvs_done_one;
            4'h9:    out_src = dvs_done_two;
            4'ha:    out_src = ext_power_enable_one;
            4'hb:    out_src = ext_power_enable_two;
            4'hc:    out_src = system_supply_good;
            4'hd:    out_src = converter_power_good;
            4'he:    out_src = ext_power_clk;
            4'hf:    out_src = aux_reset;
            default: out_src = 1'b0;
        endcase
    end
    assign out_lvl = out_src ^ !pin_polarity;

    assign access = psel && penable && s_q.pready;

    always_comb begin
        s_d         = s_q;
        s_d.pin     = pin_in;
        s_d.lf      = lf_clk;
        s_d.lf_tick = lf_clk && !s_q.lf;
        // one wait state keeps prdata and pready straight from flops
        s_d.pready  = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;
        s_d.prdata  = '0;
        if (psel && penable && !s_q.pready) begin
            case (paddr)
                `MFP_CTRL_ADDR:    s_d.prdata[15:0] = s_q.ctrl;
                `MFP_IRQ_STS_ADDR: s_d.prdata[`MFP_IRQ_EDGE_BIT] = s_q.irq_sts;
                `MFP_IRQ_MSK_ADDR: s_d.prdata[`MFP_IRQ_EDGE_BIT] = s_q.irq_msk;
                `MFP_PIN_STS_ADDR: begin
                    s_d.prdata[`MFP_PIN_RAW_BIT] = s_q.pin;
                    s_d.prdata[`MFP_PIN_ACT_BIT] = active_eff;
                    s_d.prdata[`MFP_PIN_OE_BIT]  = s_q.pin_oe;
                end
                default:           s_d.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite && paddr == `MFP_CTRL_ADDR) begin
            s_d.ctrl = pwdata[15:0] & `MFP_CTRL_WMASK;
        end
        if (access && pwrite && paddr == `MFP_IRQ_MSK_ADDR) begin
            s_d.irq_msk = pwdata[`MFP_IRQ_EDGE_BIT];
        end
        // a new edge in the clearing cycle wins over the clear
        if (access && pwrite && paddr == `MFP_IRQ_STS_ADDR
                && pwdata[`MFP_IRQ_EDGE_BIT]) begin
            s_d.irq_sts = 1'b0;
        end
        if (edge_pulse) begin
            s_d.irq_sts = 1'b1;
        end
        s_d.irq = s_d.irq_sts && s_d.irq_msk;
        s_d.pu  = pin_pull_select == MFP_PULL_UP;
        s_d.pd  = pin_pull_select == MFP_PULL_DOWN;
        s_d.dom = pin_supply_domain;
        if (!out_mode) begin
            s_d.pin_oe  = 1'b0;
            s_d.pin_out = 1'b0;
        end else if (pin_open_drain) begin
            // open drain only sinks; a high level releases the pin
            s_d.pin_oe  = !out_lvl;
            s_d.pin_out = 1'b0;
        end else begin
            s_d.pin_oe  = 1'b1;
            s_d.pin_out = out_lvl;
        end
        s_d.in_fn[0]  = in_hit[0] || in_hit[1];
        s_d.in_fn[1]  = in_hit[2];
        s_d.in_fn[2]  = in_hit[3] || in_hit[4];
        s_d.in_fn[3]  = in_hit[5];
        s_d.in_fn[4]  = in_hit[6];
        s_d.in_fn[5]  = in_hit[7];
        s_d.in_fn[6]  = in_hit[8];
        s_d.in_fn[7]  = in_hit[9];
        s_d.in_fn[8]  = in_hit[10];
        s_d.in_fn[9]  = in_hit[11];
        s_d.in_fn[10] = in_hit[12] || in_hit[14];
        s_d.in_fn[11] = in_hit[13] || in_hit[15];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.ctrl <= `MFP_CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata                   = s_q.prdata;
    assign pready                   = s_q.pready;
    assign pslverr                  = s_q.pslverr;
    assign irq                      = s_q.irq;
    assign pin_out                  = s_q.pin_out;
    assign pin_oe                   = s_q.pin_oe;
    assign pull_up_en               = s_q.pu;
    assign pull_down_en             = s_q.pd;
    assign supply_sel               = s_q.dom;
    assign gp_input_level           = s_q.in_fn[0];
    assign power_toggle_req         = s_q.in_fn[1];
    assign sleep_wake_req           = s_q.in_fn[2];
    assign sleep_req                = s_q.in_fn[3];
    assign power_on_req             = s_q.in_fn[4];
    assign watchdog_kick            = s_q.in_fn[5];
    assign voltage_scale_select_one = s_q.in_fn[6];
    assign voltage_scale_select_two = s_q.in_fn[7];
    assign hw_enable_one            = s_q.in_fn[8];
    assign hw_enable_two            = s_q.in_fn[9];
    assign hw_control_one           = s_q.in_fn[10];
    assign hw_control_two           = s_q.in_fn[11];

    sequence ctrl_write_s;
        psel && penable && pready && pwrite && paddr == `MFP_CTRL_ADDR;
    endsequence

    pull_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctrl_write_s |=> ##1 pull_down_en == ($past(pwdata[14:13], 2) == 2'h1)
            && pull_up_en == ($past(pwdata[14:13], 2) == 2'h2))
        else $error("pull enables do not follow the pull field");

    supply_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ctrl_write_s |=> ##1 supply_sel == $past(pwdata[`MFP_DOM_BIT], 2))
        else $error("supply select does not follow the domain bit");

    gpo_polarity_a: assert property (@(posedge mclk) disable iff (!rst_n)
        out_mode && !pin_open_drain && pin_function_select == 4'h0
            |=> pin_out == ($past(pin_out_level) ^ !$past(pin_polarity)))
        else $error("gpio output level ignores polarity");

    open_drain_a: assert property (@(posedge mclk) disable iff (!rst_n)
        out_mode && pin_open_drain |=> !pin_out && pin_oe == !$past(out_lvl))
        else $error("open-drain pin drove high");

    tristate_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !pin_enable [*2] |-> !pin_oe)
        else $error("disabled pin is driven");

    input_dir_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pin_direction |=> !pin_oe && ($past(pin_enable) || !gp_input_level))
        else $error("input pin drove or disabled input reported");

    power_req_a: assert property (@(posedge mclk) disable iff (!rst_n)
        in_mode && pin_function_select == 4'h2 && active_eff
            |=> power_toggle_req && !sleep_req && !power_on_req)
        else $error("power toggle request not routed");

    watchdog_a: assert property (@(posedge mclk) disable iff (!rst_n)
        in_mode && pin_function_select == 4'h7
            |=> watchdog_kick == $past(active_eff) && !voltage_scale_select_one)
        else $error("watchdog kick not routed");

    hw_ctrl_a: assert property (@(posedge mclk) disable iff (!rst_n)
        in_mode && pin_function_select == 4'he
            |=> hw_control_one == $past(active_db) && !hw_control_two)
        else $error("debounced hardware control not routed");

    slow_clk_a: assert property (@(posedge mclk) disable iff (!rst_n)
        out_mode && !pin_open_drain && pin_polarity
            && pin_function_select == 4'h1 |=> pin_out == $past(osc_clk_slow))
        else $error("slow clock not driven on the pin");

    state_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
        out_mode && !pin_open_drain && pin_polarity
            && pin_function_select == 4'h3 |=> pin_out == $past(sleep_state))
        else $error("sleep state not driven on the pin");

    dvs_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
        out_mode && !pin_open_drain && pin_polarity
            && pin_function_select == 4'h9 |=> pin_out == $past(dvs_done_two))
        else $error("second voltage scaling done not driven");

    supply_good_a: assert property (@(posedge mclk) disable iff (!rst_n)
        out_mode && !pin_open_drain && pin_polarity
            && pin_function_select == 4'hc
            |=> pin_out == $past(system_supply_good))
        else $error("system supply good not driven");

    aux_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        out_mode && !pin_open_drain && !pin_polarity
            && pin_function_select == 4'hf |=> pin_out == !$past(aux_reset))
        else $error("inverted aux reset not driven");
endmodule

/* verif/mfp_pin_partner.sv */
/*
 * External logic on the far side of the multifunction pin: it drives
 * the pin when asked and resolves the wire level seen by the device.
 * Assumes drive requests change right after a rising mclk edge.
 */
module mfp_pin_partner (
    input  wire logic mclk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic pull_up_en,
    input  wire logic pull_down_en,
    input  wire logic drive_en,
    input  wire logic drive_val,
    output logic      pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_q = 1'b0;
    // an undriven, unpulled wire must not look like a steady level
    always @(posedge mclk) float_q <= ~float_q;
    always_comb begin
        if (pin_oe) pin_in = pin_out;
        else if (drive_en) pin_in = drive_val;
        else if (pull_up_en) pin_in = 1'b1;
        else if (pull_down_en) pin_in = 1'b0;
        else pin_in = float_q;
    end
endmodule

/* verif/mfp_pin_ctrl_tb_top.sv */
/*
 * Self-checking bench for the multifunction pin controller: register
 * access, every function code in both directions, drive types,
 * debounce and the pin interrupt.
 * Assumes the design answers APB with one wait state.
 */
`include "mfp_params.svh"
module mfp_pin_ctrl_tb_top
    import mfp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        irq, pin_in, pin_out, pin_oe, pu, pd, sup, err;
    logic        drv_en, drv_val;
    logic [15:0] paddr, src_q;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  lf_cnt;
    logic [11:0] fin;
    int          failures, tests_run, cyc;
    // expected input-function outputs, one row per function code
    logic [11:0] exp_in [16] = '{12'h001, 12'h001, 12'h002, 12'h004,
        12'h004, 12'h008, 12'h010, 12'h020, 12'h040, 12'h080, 12'h100,
        12'h200, 12'h400, 12'h800, 12'h400, 12'h800};

    mfp_pin_ctrl #(.DB_TICKS(16'h0004)) uut (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pu), .pull_down_en(pd), .supply_sel(sup),
        .lf_clk(lf_cnt[1]), .pin_out_level(src_q[0]),
        .osc_clk_slow(src_q[1]), .on_state(src_q[2]),
        .sleep_state(src_q[3]), .state_change(src_q[4]),
        .dvs_done_one(src_q[8]), .dvs_done_two(src_q[9]),
        .ext_power_enable_one(src_q[10]), .ext_power_enable_two(src_q[11]),
        .system_supply_good(src_q[12]), .converter_power_good(src_q[13]),
        .ext_power_clk(src_q[14]), .aux_reset(src_q[15]),
        .gp_input_level(fin[0]), .power_toggle_req(fin[1]),
        .sleep_wake_req(fin[2]), .sleep_req(fin[3]),
        .power_on_req(fin[4]), .watchdog_kick(fin[5]),
        .voltage_scale_select_one(fin[6]),
        .voltage_scale_select_two(fin[7]), .hw_enable_one(fin[8]),
        .hw_enable_two(fin[9]), .hw_control_one(fin[10]),
        .hw_control_two(fin[11]));

    mfp_pin_partner far (
        .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pu),
        .pull_down_en(pd), .drive_en(drv_en), .drive_val(drv_val),
        .pin_in(pin_in));

    always #10 mclk = ~mclk;
    // low-frequency clock at a quarter of mclk: one tick every 4 cycles
    always @(posedge mclk) lf_cnt <= lf_cnt + 2'h1;

    task automatic stop_test();
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] got);
        tests_run++;
        if (got !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, got);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the bench timeout ends a slave that never answers
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [15:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic setpin(input logic v, input logic en,
                          input logic [15:0] s);
        @(posedge mclk);
        drv_val <= v;
        drv_en <= en;
        src_q <= s;
    endtask

    initial begin
        {mclk, rst_n, psel, penable, pwrite, drv_val} = '0;
        {paddr, src_q, pwdata, lf_cnt} = '0;
        drv_en = 1'b1;
        {failures, tests_run, cyc} = '0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        settle(2);
        chk("pull_down_en", 1, pd);
        chk("pin_oe", 0, pin_oe);
        chk("supply_sel", 0, sup);
        rdchk("ctrl reset", `MFP_CTRL_ADDR, 32'h0000a400);
        wr(`MFP_CTRL_ADDR, 32'h0000ffff);
        rdchk("ctrl bits", `MFP_CTRL_ADDR, 32'h0000fe8f);
        settle(2);
        chk("pull code 3 up", 0, pu);
        chk("pull code 3 down", 0, pd);
        chk("supply always-on", 1, sup);
        wr(`MFP_CTRL_ADDR, 32'h00004000);
        settle(2);
        chk("pull up", 1, pu);
        chk("pull up down", 0, pd);
        apb(1'b0, 16'h4050, 32'h0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        for (int k = 0; k < 16; k++) begin
            setpin(1'b0, 1'b1, 16'h0);
            wr(`MFP_CTRL_ADDR, 32'h00008480 | 32'(k));
            settle(30);
            chk("input idle", 0, fin);
            setpin(1'b1, 1'b1, 16'h0);
            settle(30);
            chk("input fn", exp_in[k], fin);
            chk("input oe", 0, pin_oe);
            setpin(1'b0, 1'b0, 16'h0001 << k);
            wr(`MFP_CTRL_ADDR, 32'h00000480 | 32'(k));
            settle(3);
            chk("output fn", (k inside {[5:7]}) ? 0 : 1,
                pin_out);
            chk("output oe", 1, pin_oe);
        end
        setpin(1'b0, 1'b1, 16'h0);
        wr(`MFP_CTRL_ADDR, 32'h00008480);
        settle(30);
        setpin(1'b1, 1'b1, 16'h0);
        settle(4);
        chk("debounce early", 0, fin[0]);
        settle(26);
        chk("debounce late", 1, fin[0]);
        setpin(1'b0, 1'b0, 16'h0);
        wr(`MFP_CTRL_ADDR, 32'h00000080);
        settle(3);
        chk("inverted low", 1, pin_out);
        setpin(1'b0, 1'b0, 16'h0001);
        settle(3);
        chk("inverted high", 0, pin_out);
        setpin(1'b0, 1'b0, 16'h8001);
        wr(`MFP_CTRL_ADDR, 32'h0000008f);
        settle(3);
        chk("inverted aux reset", 0, pin_out);
        wr(`MFP_CTRL_ADDR, 32'h00000680);
        settle(3);
        chk("open drain off", 0, pin_oe);
        setpin(1'b0, 1'b0, 16'h0);
        settle(3);
        chk("open drain on", 1, pin_oe);
        chk("open drain low", 0, pin_out);
        wr(`MFP_CTRL_ADDR, 32'h00000400);
        settle(3);
        chk("disabled oe", 0, pin_oe);
        setpin(1'b1, 1'b1, 16'h0);
        wr(`MFP_CTRL_ADDR, 32'h00008401);
        settle(5);
        chk("disabled input", 0, fin);
        setpin(1'b0, 1'b1, 16'h0);
        wr(`MFP_CTRL_ADDR, 32'h00008481);
        wr(`MFP_IRQ_MSK_ADDR, 32'h1);
        wr(`MFP_IRQ_STS_ADDR, 32'h1);
        settle(2);
        chk("irq idle", 0, irq);
        setpin(1'b1, 1'b1, 16'h0);
        settle(5);
        chk("irq rise", 1, irq);
        rdchk("irq status", `MFP_IRQ_STS_ADDR, 32'h1);
        wr(`MFP_IRQ_STS_ADDR, 32'h1);
        setpin(1'b0, 1'b1, 16'h0);
        settle(5);
        chk("irq fall ignored", 0, irq);
        wr(`MFP_CTRL_ADDR, 32'h00009481);
        setpin(1'b1, 1'b1, 16'h0);
        settle(5);
        wr(`MFP_IRQ_STS_ADDR, 32'h1);
        setpin(1'b0, 1'b1, 16'h0);
        settle(5);
        chk("irq both fall", 1, irq);
        wr(`MFP_CTRL_ADDR, 32'h00008081);
        settle(5);
        wr(`MFP_IRQ_STS_ADDR, 32'h1);
        setpin(1'b1, 1'b1, 16'h0);
        settle(5);
        chk("irq inv rise", 0, irq);
        setpin(1'b0, 1'b1, 16'h0);
        settle(5);
        chk("irq inv fall", 1, irq);
        wr(`MFP_IRQ_MSK_ADDR, 32'h0);
        settle(2);
        chk("irq masked", 0, irq);
        rdchk("mask off", `MFP_IRQ_MSK_ADDR, 32'h0);
        rdchk("pin status", `MFP_PIN_STS_ADDR, 32'h2);
        rdchk("status kept", `MFP_IRQ_STS_ADDR, 32'h1);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rdchk("ctrl re-reset", `MFP_CTRL_ADDR, 32'h0000a400);
        chk("pull re-reset", 1, pd);
        chk("oe re-reset", 0, pin_oe);
        stop_test();
    end
endmodule
